// file: chg_battery_model.sv
// Behavioural battery and its comparators, seen from the charger.
`timescale 1ns/1ns
module chg_battery_model (
    input wire logic clk,
    input wire logic chargeEnable,
    input wire logic trickleMode,
    input wire logic stuck,
    input wire logic drain,
    output logic batBelowTrickle,
    output logic batAtFloat,
    output logic batBelowRecharge,
    output logic chargeBelowTenth
);
    int mv = 2500;
    int floatCycles = 0;
    // Levels move only after falling edges, so the charger samples them settled.
    always @(negedge clk) begin
        if (stuck) begin
            mv = 2500;
        end else if (chargeEnable) begin
            mv = mv + (trickleMode ? 5 : 10);
            if (mv > 4200) begin
                mv = 4200;
            end
        end else if (drain && mv > 4050) begin
            mv = mv - 1;
        end
        floatCycles = (mv == 4200 && chargeEnable) ? floatCycles + 1 : 0;
        batBelowTrickle <= mv < 2850;
        batAtFloat <= mv == 4200;
        batBelowRecharge <= mv < 4100;
        chargeBelowTenth <= floatCycles >= 20;
    end
endmodule // chg_battery_model

// file: chg_pkg.sv
// Shared constants and types for the charger sequencer and status encoder.
package chg_pkg;
    localparam int unsigned CLK_HZ = 50000000;
    localparam real SAFETY_HOURS = 4.0;
    localparam real BADCELL_HOURS = 0.5;
    localparam real RECHARGE_FILTER_MS = 1.3;
    localparam real PULSE_KHZ = 35.0;
    localparam real BLINK_THERM_HZ = 1.5;
    localparam real BLINK_BAD_HZ = 6.1;
    // Least times round up; periods round down.
    localparam longint SAFETY_CYCLES = longint'(SAFETY_HOURS * 3600.0 * CLK_HZ);
    localparam longint BADCELL_CYCLES = longint'(BADCELL_HOURS * 3600.0 * CLK_HZ);
    localparam int RECHARGE_FILTER_CYCLES = int'($ceil(RECHARGE_FILTER_MS * CLK_HZ / 1000.0));
    localparam int PULSE_PERIOD_CYCLES = int'($floor(CLK_HZ / (PULSE_KHZ * 1000.0)));
    localparam int BLINK_THERM_HALF_CYCLES = int'($floor(CLK_HZ / BLINK_THERM_HZ / 2.0));
    localparam int BLINK_BAD_HALF_CYCLES = int'($floor(CLK_HZ / BLINK_BAD_HZ / 2.0));
    // Duty cycles in sixteenths of the pulse period.
    localparam logic [4:0] DUTY_THERM_LOW = 5'h01;
    localparam logic [4:0] DUTY_THERM_HIGH = 5'h0F;
    localparam logic [4:0] DUTY_BAD_LOW = 5'h02;
    localparam logic [4:0] DUTY_BAD_HIGH = 5'h0E;
    localparam int DUTY_DEN = 16;

    typedef enum logic [2:0] {
        CHG_OFF = 3'h0,
        CHG_TRICKLE = 3'h1,
        CHG_CC = 3'h2,
        CHG_FLOAT = 3'h3,
        CHG_DONE = 3'h4,
        CHG_BADCELL = 3'h5
    } chg_state_e;

    typedef enum logic [1:0] {
        STS_CHARGING = 2'h0,
        STS_IDLE = 2'h1,
        STS_THERM = 2'h2,
        STS_BAD = 2'h3
    } chg_status_e;
endpackage

// file: chg_props.sv
// Concurrent checks on the charger sequencer ports.
`timescale 1ns/1ns
module chg_props #(
    parameter longint SAFETY_CYCLES = 200,
    parameter longint BADCELL_CYCLES = 100
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic busAboveUpper,
    input wire logic busMarginHigh,
    input wire logic busMarginLow,
    input wire logic inputCurrentLimit,
    input wire logic thermHot,
    input wire logic thermCold,
    input wire logic thermGrounded,
    input wire logic converterEnable,
    input wire logic chargeEnable,
    input wire logic trickleMode,
    input wire logic charge_status_pin_o,
    input wire logic charge_status_pin_oe,
    input wire logic [2:0] chargeState
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_fault;
        (thermHot || thermCold) && !thermGrounded;
    endsequence
    property p_off_below;
        (!busMarginLow)[*5] |-> !converterEnable;
    endproperty
    a_off_below: assert property (p_off_below) else $error("converter on");
    property p_stay_off;
        (!busAboveUpper || !busMarginHigh)[*6] ##0 !converterEnable |=> !converterEnable;
    endproperty
    a_stay_off: assert property (p_stay_off) else $error("converter started");
    property p_open_drain;
        charge_status_pin_o == 1'b0;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("pin driven high");
    property p_pause;
        s_fault[*6] |-> !chargeEnable;
    endproperty
    a_pause: assert property (p_pause) else $error("charging while hot");
    property p_done;
        (chargeState == 3'h4)[*2] |-> !chargeEnable && !charge_status_pin_oe;
    endproperty
    a_done: assert property (p_done) else $error("done not idle");
    property p_bad;
        (chargeState == 3'h5)[*2] |-> !chargeEnable;
    endproperty
    a_bad: assert property (p_bad) else $error("bad cell charging");
    // Counts trickle time since the last thermal fault, so legal pauses never stretch it.
    logic [41:0] trickleRun;
    always_ff @(posedge clk) begin
        if (reset || chargeState != 3'h1 || ((thermHot || thermCold) && !thermGrounded)) begin
            trickleRun <= '0;
        end else begin
            trickleRun <= trickleRun + 1'b1;
        end
    end
    property p_bad_time;
        trickleRun <= 42'(BADCELL_CYCLES + 4);
    endproperty
    a_bad_time: assert property (p_bad_time) else $error("trickle too long");
    property p_trickle;
        trickleMode |-> chargeState == 3'h1 || $past(chargeState) == 3'h1;
    endproperty
    a_trickle: assert property (p_trickle) else $error("stray trickle");
    property p_limit;
        (chargeState == 3'h3 && inputCurrentLimit && !thermHot && !thermCold)[*6]
            |-> charge_status_pin_oe;
    endproperty
    a_limit: assert property (p_limit) else $error("released in limit");
    property p_charging;
        (chargeState inside {3'h1, 3'h2} && !thermHot && !thermCold)[*6]
            |-> charge_status_pin_oe;
    endproperty
    a_charging: assert property (p_charging) else $error("pin not low");
endmodule // chg_props

bind chg_sequencer chg_props #(.SAFETY_CYCLES(SAFETY_CYCLES), .BADCELL_CYCLES(BADCELL_CYCLES))
    chg_props_i (.clk, .reset, .busAboveUpper, .busMarginHigh, .busMarginLow,
    .inputCurrentLimit, .thermHot, .thermCold, .thermGrounded, .converterEnable,
    .chargeEnable, .trickleMode, .charge_status_pin_o, .charge_status_pin_oe, .chargeState);

// file: chg_sequencer.sv
// Charger sequencer: lockout, trickle, constant current, float timer, recharge, status pin.
`timescale 1ns/1ns
module chg_sequencer #(
    parameter longint SAFETY_CYCLES = chg_pkg::SAFETY_CYCLES,
    parameter longint BADCELL_CYCLES = chg_pkg::BADCELL_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic busAboveUpper,
    input wire logic busAboveLower,
    input wire logic busMarginHigh,
    input wire logic busMarginLow,
    input wire logic batBelowTrickle,
    input wire logic batAtFloat,
    input wire logic batBelowRecharge,
    input wire logic chargeBelowTenth,
    input wire logic inputCurrentLimit,
    input wire logic thermHot,
    input wire logic thermCold,
    input wire logic thermGrounded,
    input wire logic chargerDisable,
    output logic converterEnable,
    output logic chargeEnable,
    output logic trickleMode,
    output logic charge_status_pin_o,
    output logic charge_status_pin_oe,
    output logic [2:0] chargeState
);
    localparam int NS = 13;
    logic [NS-1:0] syncA;
    logic [NS-1:0] syncB;
    logic sAboveUpper, sAboveLower, sMarginHigh, sMarginLow, sBelowTrickle, sAtFloat;
    logic sBelowRecharge, sBelowTenth, sCurLimit, sHot, sCold, sGrounded, sDisable;
    logic busOk;
    logic busOkPrev;
    logic disablePrev;
    logic restart;
    logic thermFault;
    logic [41:0] safetyCount;
    logic [41:0] badCount;
    logic [16:0] filterCount;
    logic rechargeSeen;
    chg_pkg::chg_state_e state;
    chg_pkg::chg_state_e next_state;
    chg_pkg::chg_status_e next_status;
    chg_status_if stIf ();

    // Comparator outputs come from the analog domain, so two flops each.
    always_ff @(posedge clk) begin
        if (reset) begin
            syncA <= '0;
            syncB <= '0;
        end else begin
            syncA <= {busAboveUpper, busAboveLower, busMarginHigh, busMarginLow, batBelowTrickle,
                      batAtFloat, batBelowRecharge, chargeBelowTenth, inputCurrentLimit,
                      thermHot, thermCold, thermGrounded, chargerDisable};
            syncB <= syncA;
        end
    end
    assign {sAboveUpper, sAboveLower, sMarginHigh, sMarginLow, sBelowTrickle, sAtFloat,
            sBelowRecharge, sBelowTenth, sCurLimit, sHot, sCold, sGrounded, sDisable} = syncB;

    // Lockout with hysteresis held in a flop.
    always_ff @(posedge clk) begin
        if (reset) begin
            busOk <= 1'b0;
        end else if (!busOk && sAboveUpper && sMarginHigh) begin
            busOk <= 1'b1;
        end else if (busOk && (!sAboveLower || !sMarginLow)) begin
            busOk <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            busOkPrev <= 1'b0;
            disablePrev <= 1'b0;
        end else begin
            busOkPrev <= busOk;
            disablePrev <= sDisable;
        end
    end
    // A rising lockout or a falling disable starts a fresh cycle.
    assign restart = (busOk && !busOkPrev) || (busOk && disablePrev && !sDisable);
    assign thermFault = !sGrounded && (sHot || sCold);

    // Recharge filter: the level must hold for the whole filter time.
    always_ff @(posedge clk) begin
        if (reset || !sBelowRecharge) begin
            filterCount <= '0;
            rechargeSeen <= 1'b0;
        end else if (filterCount < 17'(chg_pkg::RECHARGE_FILTER_CYCLES)) begin
            filterCount <= filterCount + 1'b1;
            rechargeSeen <= 1'b0;
        end else begin
            // Parking the count past the limit keeps a long excursion from firing twice.
            rechargeSeen <= (filterCount == 17'(chg_pkg::RECHARGE_FILTER_CYCLES));
            if (filterCount == 17'(chg_pkg::RECHARGE_FILTER_CYCLES)) begin
                filterCount <= filterCount + 1'b1;
            end
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            chg_pkg::CHG_OFF: begin
                if (restart) begin
                    next_state = sBelowTrickle ? chg_pkg::CHG_TRICKLE : chg_pkg::CHG_CC;
                end
            end
            chg_pkg::CHG_TRICKLE: begin
                if (badCount >= 42'(BADCELL_CYCLES)) begin
                    next_state = chg_pkg::CHG_BADCELL;
                end else if (!sBelowTrickle) begin
                    next_state = chg_pkg::CHG_CC;
                end
            end
            chg_pkg::CHG_CC: begin
                if (sAtFloat) begin
                    next_state = chg_pkg::CHG_FLOAT;
                end
            end
            chg_pkg::CHG_FLOAT: begin
                if (safetyCount >= 42'(SAFETY_CYCLES)) begin
                    next_state = chg_pkg::CHG_DONE;
                end
            end
            chg_pkg::CHG_DONE: begin
                if (rechargeSeen) begin
                    next_state = chg_pkg::CHG_CC;
                end
            end
            chg_pkg::CHG_BADCELL: next_state = chg_pkg::CHG_BADCELL;
            default: next_state = chg_pkg::CHG_OFF;
        endcase
        if (restart && state != chg_pkg::CHG_OFF) begin
            next_state = sBelowTrickle ? chg_pkg::CHG_TRICKLE : chg_pkg::CHG_CC;
        end
        if (!busOk || sDisable) begin
            next_state = chg_pkg::CHG_OFF;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state <= chg_pkg::CHG_OFF;
        end else begin
            state <= next_state;
        end
    end

    // Safety timer runs only in float; a thermistor fault freezes it.
    always_ff @(posedge clk) begin
        if (reset || restart || state != chg_pkg::CHG_FLOAT) begin
            safetyCount <= '0;
        end else if (rechargeSeen) begin
            safetyCount <= '0;
        end else if (!thermFault) begin
            safetyCount <= safetyCount + 1'b1;
        end
    end

    // Bad-cell timer counts trickle time; it pauses with charging.
    always_ff @(posedge clk) begin
        if (reset || state != chg_pkg::CHG_TRICKLE) begin
            badCount <= '0;
        end else if (!thermFault) begin
            badCount <= badCount + 1'b1;
        end
    end

    always_comb begin
        next_status = chg_pkg::STS_IDLE;
        if (state == chg_pkg::CHG_BADCELL) begin
            next_status = chg_pkg::STS_BAD;
        end else if (state == chg_pkg::CHG_OFF || state == chg_pkg::CHG_DONE) begin
            next_status = chg_pkg::STS_IDLE;
        end else if (thermFault) begin
            next_status = chg_pkg::STS_THERM;
        end else if (state == chg_pkg::CHG_FLOAT && sBelowTenth && !sCurLimit) begin
            next_status = chg_pkg::STS_IDLE;
        end else begin
            next_status = chg_pkg::STS_CHARGING;
        end
    end
    assign stIf.status = next_status;

    chg_status_encoder encoder (
        .clk(clk),
        .reset(reset),
        .st(stIf)
    );

    always_ff @(posedge clk) begin
        if (reset) begin
            converterEnable <= 1'b0;
            chargeEnable <= 1'b0;
            trickleMode <= 1'b0;
            charge_status_pin_oe <= 1'b0;
            charge_status_pin_o <= 1'b0;
            chargeState <= 3'h0;
        end else begin
            converterEnable <= busOk;
            chargeEnable <= (state == chg_pkg::CHG_TRICKLE || state == chg_pkg::CHG_CC ||
                             state == chg_pkg::CHG_FLOAT) && !thermFault;
            trickleMode <= (state == chg_pkg::CHG_TRICKLE);
            charge_status_pin_oe <= stIf.pinLow;
            charge_status_pin_o <= 1'b0;
            chargeState <= state;
        end
    end
endmodule // chg_sequencer

// file: chg_sequencer_tb_top.sv
// Self-checking bench for the charger sequencer with a behavioural battery.
`timescale 1ns/1ns
module chg_sequencer_tb_top;
    localparam int SAFE = 200;
    localparam int BAD = 100;
    localparam int PER = chg_pkg::PULSE_PERIOD_CYCLES;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic busAboveUpper = 1'b0, busAboveLower = 1'b0, busMarginHigh = 1'b0, busMarginLow = 1'b0;
    logic inputCurrentLimit = 1'b0, thermHot = 1'b0, thermCold = 1'b0, thermGrounded = 1'b0;
    logic chargerDisable = 1'b0, stuck = 1'b0, drain = 1'b0;
    logic batBelowTrickle, batAtFloat, batBelowRecharge, chargeBelowTenth;
    logic converterEnable, chargeEnable, trickleMode, statusData, statusPull;
    logic [2:0] chargeState;
    int n_mismatch = 0;
    int checks = 0;
    int n;
    always #10 clk = ~clk;
    chg_sequencer #(.SAFETY_CYCLES(SAFE), .BADCELL_CYCLES(BAD)) chg_sequencer_i (.clk, .reset,
        .busAboveUpper, .busAboveLower, .busMarginHigh, .busMarginLow, .batBelowTrickle,
        .batAtFloat, .batBelowRecharge, .chargeBelowTenth, .inputCurrentLimit, .thermHot,
        .thermCold, .thermGrounded, .chargerDisable, .converterEnable, .chargeEnable,
        .trickleMode, .charge_status_pin_o(statusData), .charge_status_pin_oe(statusPull),
        .chargeState);
    chg_battery_model chg_battery_model_i (.clk, .chargeEnable, .trickleMode, .stuck, .drain,
        .batBelowTrickle, .batAtFloat, .batBelowRecharge, .chargeBelowTenth);
    task automatic chk(input logic [2:0] got, input logic [2:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic chkr(input int got, input int lo, input int hi);
        checks++;
        if (got < lo || got > hi) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: count %0d not in %0d..%0d", $time, got, lo, hi);
        end
    endtask
    task automatic wait_st(input logic [2:0] s, input int lim, output int cnt);
        for (cnt = 0; cnt < lim && chargeState !== s; cnt++) @(negedge clk);
        chk(chargeState, s);
    endtask
    task automatic bus(input logic [3:0] v);
        {busAboveUpper, busAboveLower, busMarginHigh, busMarginLow} = v;
        repeat (10) @(negedge clk);
    endtask
    task automatic meas(input int duty);
        int h;
        int p;
        // A reading taken across a blink edge shows exactly half and is taken again.
        do begin
            h = 0;
            for (n = 0; n < 3000 && statusPull !== 1'b0; n++) @(negedge clk);
            for (n = 0; n < 3000 && statusPull !== 1'b1; n++) @(negedge clk);
            while (statusPull === 1'b1 && h < 3000) begin
                h++;
                @(negedge clk);
            end
            p = h;
            while (statusPull === 1'b0 && p < 3000) begin
                p++;
                @(negedge clk);
            end
        end while (2 * h == p);
        chkr(p, PER - 1, PER + 1);
        chkr(h, duty * PER / 16 - 1, duty * PER / 16 + 1);
    endtask
    task automatic t_lockout();
        chk(converterEnable, 1'b0);
        bus(4'hD);
        chk(converterEnable, 1'b0);
        bus(4'hF);
        chk(converterEnable, 1'b1);
        bus(4'h5);
        chk(converterEnable, 1'b1);
        bus(4'h4);
        chk(converterEnable, 1'b0);
        bus(4'hF);
        chk(converterEnable, 1'b1);
        bus(4'h3);
        chk(converterEnable, 1'b0);
        bus(4'hF);
        wait_st(3'h1, 20, n);
    endtask
    task automatic t_charge();
        @(negedge clk);
        chk(trickleMode, 1'b1);
        chk(statusPull, 1'b1);
        inputCurrentLimit = 1'b1;
        wait_st(3'h2, 200, n);
        @(negedge clk);
        chk(trickleMode, 1'b0);
        wait_st(3'h3, 300, n);
        repeat (40) @(negedge clk);
        chk(statusPull, 1'b1);
        inputCurrentLimit = 1'b0;
        repeat (10) @(negedge clk);
        chk(statusPull, 1'b0);
        wait_st(3'h4, SAFE, n);
        chkr(n + 50, SAFE - 2, SAFE + 2);
        @(negedge clk);
        chk(chargeEnable, 1'b0);
        drain = 1'b1;
        repeat (60000) @(negedge clk);
        chk(chargeState, 3'h4);
        wait_st(3'h2, 8000, n);
        drain = 1'b0;
    endtask
    task automatic t_therm();
        wait_st(3'h3, 100, n);
        thermHot = 1'b1;
        repeat (10) @(negedge clk);
        chk(chargeEnable, 1'b0);
        meas(chg_pkg::DUTY_THERM_LOW);
        repeat (SAFE) @(negedge clk);
        chk(chargeState, 3'h3);
        thermHot = 1'b0;
        thermCold = 1'b1;
        thermGrounded = 1'b1;
        repeat (10) @(negedge clk);
        chk(chargeEnable, 1'b1);
        thermCold = 1'b0;
        thermGrounded = 1'b0;
    endtask
    task automatic t_badcell();
        stuck = 1'b1;
        chargerDisable = 1'b1;
        repeat (10) @(negedge clk);
        chk(chargeEnable, 1'b0);
        chargerDisable = 1'b0;
        wait_st(3'h1, 20, n);
        wait_st(3'h5, BAD + 20, n);
        chkr(n, BAD - 10, BAD + 2);
        @(negedge clk);
        chk(chargeEnable, 1'b0);
        meas(chg_pkg::DUTY_BAD_LOW);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge clk);
        reset = 1'b0;
        @(negedge clk);
        t_lockout();
        t_charge();
        t_therm();
        t_badcell();
        end_of_test();
    end
    // The tests need about 72000 cycles; the limit still keeps a hang under 100000.
    initial begin
        #(20 * 95000);
        n_mismatch++;
        end_of_test();
    end
endmodule // chg_sequencer_tb_top

// file: chg_status_encoder.sv
// Pulse-train encoder for the charge status pin.
`timescale 1ns/1ns
module chg_status_encoder (
    input wire logic clk,
    input wire logic reset,
    chg_status_if.enc st
);
    localparam int PW = $clog2(chg_pkg::PULSE_PERIOD_CYCLES);
    localparam int BW = $clog2(chg_pkg::BLINK_THERM_HALF_CYCLES + 1);
    logic [PW-1:0] phase;
    logic [BW-1:0] blinkCount;
    logic blinkHigh;
    logic [PW+4:0] threshold;
    logic [4:0] duty;
    logic [BW-1:0] halfLen;

    always_comb begin
        halfLen = (st.status == chg_pkg::STS_THERM) ? BW'(chg_pkg::BLINK_THERM_HALF_CYCLES - 1)
                                                    : BW'(chg_pkg::BLINK_BAD_HALF_CYCLES - 1);
        if (st.status == chg_pkg::STS_THERM) begin
            duty = blinkHigh ? chg_pkg::DUTY_THERM_HIGH : chg_pkg::DUTY_THERM_LOW;
        end else begin
            duty = blinkHigh ? chg_pkg::DUTY_BAD_HIGH : chg_pkg::DUTY_BAD_LOW;
        end
        threshold = (PW+5)'(duty) * (PW+5)'(chg_pkg::PULSE_PERIOD_CYCLES) / (PW+5)'(chg_pkg::DUTY_DEN);
    end

    // Fixed 35 kHz carrier.
    always_ff @(posedge clk) begin
        if (reset || phase == PW'(chg_pkg::PULSE_PERIOD_CYCLES - 1)) begin
            phase <= '0;
        end else begin
            phase <= phase + 1'b1;
        end
    end

    // Equal halves of the blink; restarts whenever a fault is not shown.
    always_ff @(posedge clk) begin
        if (reset || st.status == chg_pkg::STS_CHARGING || st.status == chg_pkg::STS_IDLE) begin
            blinkCount <= '0;
            blinkHigh <= 1'b0;
        end else if (blinkCount >= halfLen) begin
            blinkCount <= '0;
            blinkHigh <= ~blinkHigh;
        end else begin
            blinkCount <= blinkCount + 1'b1;
        end
    end

    always_comb begin
        case (st.status)
            chg_pkg::STS_CHARGING: st.pinLow = 1'b1;
            chg_pkg::STS_IDLE: st.pinLow = 1'b0;
            default: st.pinLow = ((PW+5)'(phase) < threshold);
        endcase
    end
endmodule // chg_status_encoder

// file: chg_status_if.sv
// Status request from the sequencer to the open-drain status encoder.
`timescale 1ns/1ns
interface chg_status_if;
    chg_pkg::chg_status_e status;
    logic pinLow;
    modport src (output status, input pinLow);
    modport enc (input status, output pinLow);
endinterface
